// *** sstio_map.vh ***
/*
 * Constants for the second serial terminal interface: device codes, pulse bits,
 * frame layout and bit-timing ratios.
 * Assumes inclusion by its bare name from the design file.
 */
`ifndef SSTIO_MAP_VH
`define SSTIO_MAP_VH

// ----------------------------------------------------------------------------
// Processor I/O device codes and pulses
// ----------------------------------------------------------------------------
`define SSTIO_RX_CODE 6'h20
`define SSTIO_TX_CODE 6'h21
`define SSTIO_PULSE_SKIP 0
`define SSTIO_PULSE_CLEAR 1
`define SSTIO_PULSE_XFER 2

// ----------------------------------------------------------------------------
// Accumulator field and character frame
// ----------------------------------------------------------------------------
`define SSTIO_AC_CHAR_MSB 11
`define SSTIO_AC_CHAR_LSB 4
`define SSTIO_DATA_BITS 4'h8

// ----------------------------------------------------------------------------
// Bit timing
// ----------------------------------------------------------------------------
`define SSTIO_RATIO_LOW 8'h80
`define SSTIO_RATIO_HIGH 8'h10
`define SSTIO_TERM_BAUD 110
`define SSTIO_CLK_HZ 50000000
`define SSTIO_DEF_BAUD 110
`define SSTIO_HIGH_RANGE_BAUD 10000
`define SSTIO_MAX_BAUD 100000

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SSTIO_RST_TX_DONE 1'b0
`define SSTIO_RST_RX_READY 1'b0

`endif

// *** sstio_top.v ***
/*
 * Second serial terminal interface: one asynchronous character port answering
 * two processor I/O device codes, with a receive channel and a transmit channel.
 * Assumes a processor I/O bus giving a device code, a 3-bit pulse group strobe and
 * a 12-bit accumulator, and a crystal tick input at 128 or 16 times the baud rate.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sstio_map.vh"

module sstio_top
(
  // Clock and reset
  input wire clock_i,
  input wire reset_n_i,
  input wire enable_i,
  // Build options and crystal tick
  input wire fitted_i,
  input wire modem_sel_i,
  input wire high_rate_strap_i,
  input wire xtal_tick_i,
  // Processor I/O bus
  input wire io_strobe_i,
  input wire [5:0] io_code_i,
  input wire [2:0] io_pulse_i,
  input wire [11:0] ac_i,
  output reg [11:0] ac_o,
  output reg ac_valid_o,
  output reg skip_o,
  // Serial line and flags
  input wire receive_serial_input_i,
  output reg tx_serial_o,
  output reg receive_ready_flag_o,
  output reg transmit_done_flag_o
);

  // --------------------------------------------------------------------------
  // Timing constants
  // --------------------------------------------------------------------------
  // The terminal variant derives its 128x reference from the system clock.
  localparam integer TERM_DIV = `SSTIO_CLK_HZ / (`SSTIO_TERM_BAUD * 128);
  localparam [7:0] RATIO_LOW = `SSTIO_RATIO_LOW;
  localparam [7:0] RATIO_HIGH = `SSTIO_RATIO_HIGH;
  localparam [3:0] NBITS = `SSTIO_DATA_BITS;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_START = 2'h1;
  localparam [1:0] ST_DATA = 2'h2;
  localparam [1:0] ST_STOP = 2'h3;

  // --------------------------------------------------------------------------
  // Input synchronisers and strap capture
  // --------------------------------------------------------------------------
  reg [1:0] rx_sync_q;
  reg [1:0] xt_sync_q;
  reg [1:0] strap_sync_q;
  reg xt_prev_q;
  reg [1:0] strap_age_q;
  reg high_rate_q;

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_sync_q <= 2'h3;
      xt_sync_q <= 2'h0;
      strap_sync_q <= 2'h0;
      xt_prev_q <= 1'b0;
      strap_age_q <= 2'h0;
      high_rate_q <= 1'b0;
    end
    else if (enable_i)
    begin
      rx_sync_q <= {rx_sync_q[0], receive_serial_input_i};
      xt_sync_q <= {xt_sync_q[0], xtal_tick_i};
      strap_sync_q <= {strap_sync_q[0], high_rate_strap_i};
      xt_prev_q <= xt_sync_q[1];
      // The strap is static; it is taken once, after the synchroniser has filled with its level.
      if (strap_age_q != 2'h3)
        strap_age_q <= strap_age_q + 2'h1;
      if (strap_age_q == 2'h2)
        high_rate_q <= strap_sync_q[1];
    end
  end

  // With nothing fitted the line reads as a held start level, so no frame ever completes.
  wire rx_line = fitted_i & rx_sync_q[1];

  // --------------------------------------------------------------------------
  // Reference tick: terminal divider or crystal edge
  // --------------------------------------------------------------------------
  reg [15:0] term_cnt_q;
  wire term_tick = (term_cnt_q == 16'h0000);
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      term_cnt_q <= 16'h0000;
    else if (enable_i)
      term_cnt_q <= term_tick ? TERM_DIV[15:0] - 16'h0001 : term_cnt_q - 16'h0001;
  end

  wire xt_tick = xt_sync_q[1] & ~xt_prev_q;
  wire ref_tick = modem_sel_i ? xt_tick : term_tick;
  // Terminal variant always uses the 128x divide.
  wire [7:0] ratio = (modem_sel_i & high_rate_q) ? RATIO_HIGH : RATIO_LOW;
  wire [7:0] half_ratio = {1'b0, ratio[7:1]};

  // --------------------------------------------------------------------------
  // Processor I/O decode
  // --------------------------------------------------------------------------
  wire sel_rx = io_strobe_i & (io_code_i == `SSTIO_RX_CODE) & fitted_i;
  wire sel_tx = io_strobe_i & (io_code_i == `SSTIO_TX_CODE) & fitted_i;
  wire rx_clear = sel_rx & io_pulse_i[`SSTIO_PULSE_CLEAR];
  wire rx_read = sel_rx & io_pulse_i[`SSTIO_PULSE_XFER];
  wire tx_clear = sel_tx & io_pulse_i[`SSTIO_PULSE_CLEAR];
  wire tx_load = sel_tx & io_pulse_i[`SSTIO_PULSE_XFER];

  // --------------------------------------------------------------------------
  // Receive channel
  // --------------------------------------------------------------------------
  reg [1:0] rx_st_q;
  reg [7:0] rx_div_q;
  reg [3:0] rx_bit_q;
  reg [7:0] rx_shift_q;
  reg [7:0] rx_buf_q;
  wire rx_done_ev = ref_tick & (rx_st_q == ST_STOP) & (rx_div_q == 8'h00) & rx_line;

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_st_q <= ST_IDLE;
      rx_div_q <= 8'h00;
      rx_bit_q <= 4'h0;
      rx_shift_q <= 8'h00;
      rx_buf_q <= 8'h00;
      receive_ready_flag_o <= `SSTIO_RST_RX_READY;
    end
    else if (enable_i)
    begin
      if (rx_done_ev)
        receive_ready_flag_o <= 1'b1;
      else if (rx_clear)
        receive_ready_flag_o <= 1'b0;
      if (rx_done_ev)
        rx_buf_q <= rx_shift_q;
      // Every state but idle waits out its divider first; idle always finds it at zero.
      if (ref_tick && rx_div_q != 8'h00)
        rx_div_q <= rx_div_q - 8'h01;
      else if (ref_tick)
      begin
        case (rx_st_q)
          ST_IDLE:
            if (!rx_line)
            begin
              rx_st_q <= ST_START;
              rx_div_q <= half_ratio - 8'h01;
            end
          ST_START:
            if (rx_line)
              rx_st_q <= ST_IDLE;
            else
            begin
              rx_st_q <= ST_DATA;
              rx_div_q <= ratio - 8'h01;
              rx_bit_q <= 4'h0;
            end
          ST_DATA:
          begin
            rx_shift_q <= {rx_line, rx_shift_q[7:1]};
            rx_div_q <= ratio - 8'h01;
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == NBITS - 4'h1)
              rx_st_q <= ST_STOP;
          end
          ST_STOP:
            rx_st_q <= ST_IDLE;
          default:
            rx_st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Transmit channel
  // --------------------------------------------------------------------------
  reg [1:0] tx_st_q;
  reg [7:0] tx_div_q;
  reg [3:0] tx_bit_q;
  reg [7:0] tx_shift_q;
  wire tx_end_ev = ref_tick & (tx_st_q == ST_STOP) & (tx_div_q == 8'h00);

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_st_q <= ST_IDLE;
      tx_div_q <= 8'h00;
      tx_bit_q <= 4'h0;
      tx_shift_q <= 8'h00;
      tx_serial_o <= 1'b1;
      transmit_done_flag_o <= `SSTIO_RST_TX_DONE;
    end
    else if (enable_i)
    begin
      if (tx_end_ev)
        transmit_done_flag_o <= 1'b1;
      else if (tx_clear)
        transmit_done_flag_o <= 1'b0;
      // A load while a frame is running restarts with the new character.
      if (tx_load)
      begin
        tx_shift_q <= ac_i[`SSTIO_AC_CHAR_MSB:`SSTIO_AC_CHAR_LSB];
        tx_st_q <= ST_START;
        tx_div_q <= ratio - 8'h01;
        tx_serial_o <= 1'b0;
      end
      else if (ref_tick && tx_div_q != 8'h00)
        tx_div_q <= tx_div_q - 8'h01;
      else if (ref_tick)
      begin
        case (tx_st_q)
          ST_IDLE:
            tx_serial_o <= 1'b1;
          ST_START:
          begin
            tx_st_q <= ST_DATA;
            tx_div_q <= ratio - 8'h01;
            tx_bit_q <= 4'h0;
            tx_serial_o <= tx_shift_q[0];
          end
          ST_DATA:
            if (tx_bit_q == NBITS - 4'h1)
            begin
              tx_st_q <= ST_STOP;
              tx_div_q <= ratio - 8'h01;
              tx_serial_o <= 1'b1;
            end
            else
            begin
              tx_shift_q <= {1'b0, tx_shift_q[7:1]};
              tx_serial_o <= tx_shift_q[1];
              tx_bit_q <= tx_bit_q + 4'h1;
              tx_div_q <= ratio - 8'h01;
            end
          ST_STOP:
            tx_st_q <= ST_IDLE;
          default:
            tx_st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Answers to the processor
  // --------------------------------------------------------------------------
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ac_o <= 12'h000;
      ac_valid_o <= 1'b0;
      skip_o <= 1'b0;
    end
    else if (enable_i)
    begin
      skip_o <= (sel_rx & io_pulse_i[`SSTIO_PULSE_SKIP] & receive_ready_flag_o) |
                (sel_tx & io_pulse_i[`SSTIO_PULSE_SKIP] & transmit_done_flag_o);
      ac_valid_o <= sel_rx & (rx_clear | rx_read);
      // Clear alone returns zero; read ORs the character into the kept or cleared AC.
      ac_o <= (rx_clear ? 12'h000 : ac_i) |
              (rx_read ? {rx_buf_q, 4'h0} : 12'h000);
    end
  end

endmodule
`default_nettype wire

// *** sstio_props.sv ***
/*
 Checker for the serial terminal interface top: I/O bus answers, flags and line framing.
 Assumes it is bound to sstio_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sstio_map.vh"
module sstio_props
(
  // Clock, reset, enable and fitted option
  input wire clock_i,
  input wire reset_n_i,
  input wire enable_i,
  input wire fitted_i,
  // Processor I/O bus
  input wire io_strobe_i,
  input wire [5:0] io_code_i,
  input wire [2:0] io_pulse_i,
  input wire [11:0] ac_i,
  input wire [11:0] ac_o,
  input wire ac_valid_o,
  input wire skip_o,
  // Serial line and flags
  input wire tx_serial_o,
  input wire receive_ready_flag_o,
  input wire transmit_done_flag_o
);
  wire go = io_strobe_i && fitted_i && enable_i;
  wire rx_hit = go && io_code_i == `SSTIO_RX_CODE;
  wire tx_hit = go && io_code_i == `SSTIO_TX_CODE;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  property p_ans; rx_hit && io_pulse_i[2:1] != 2'h0 |=> ac_valid_o; endproperty
  a_ans: assert property (p_ans) else $error("no answer to a receive read");
  property p_refuse; io_strobe_i && !fitted_i |=> !ac_valid_o && !skip_o; endproperty
  a_refuse: assert property (p_refuse) else $error("answer while nothing fitted");
  property p_skip; rx_hit && io_pulse_i[0] |=> skip_o == $past(receive_ready_flag_o); endproperty
  a_skip: assert property (p_skip) else $error("skip does not follow the ready flag");
  property p_dyn; rx_hit && io_pulse_i[1] |=> ac_o[3:0] == 4'h0; endproperty
  a_dyn: assert property (p_dyn) else $error("accumulator not cleared");
  property p_static; rx_hit && io_pulse_i == 3'h4 |=> ac_o[3:0] == $past(ac_i[3:0]); endproperty
  a_static: assert property (p_static) else $error("static read lost low bits");
  property p_load; tx_hit && io_pulse_i[2:1] == 2'h3 |=> !tx_serial_o && !transmit_done_flag_o; endproperty
  a_load: assert property (p_load) else $error("load did not start a frame");
  property p_self; skip_o || ac_valid_o |-> $past(io_strobe_i && fitted_i); endproperty
  a_self: assert property (p_self) else $error("bus answer without a request");
  property p_stop; $rose(transmit_done_flag_o) |-> tx_serial_o; endproperty
  a_stop: assert property (p_stop) else $error("done flag rose off the stop level");
  property p_rxfit; $rose(receive_ready_flag_o) |-> fitted_i; endproperty
  a_rxfit: assert property (p_rxfit) else $error("ready flag rose while unfitted");
endmodule
bind sstio_top sstio_props u_props (.clock_i(clock_i), .reset_n_i(reset_n_i), .enable_i(enable_i),
  .fitted_i(fitted_i), .io_strobe_i(io_strobe_i), .io_code_i(io_code_i), .io_pulse_i(io_pulse_i),
  .ac_i(ac_i), .ac_o(ac_o), .ac_valid_o(ac_valid_o), .skip_o(skip_o), .tx_serial_o(tx_serial_o),
  .receive_ready_flag_o(receive_ready_flag_o), .transmit_done_flag_o(transmit_done_flag_o));
`default_nettype wire

// *** sstio_term.sv ***
/*
 Behavioural far-side terminal: frames characters onto its line and decodes the line it hears.
 Assumes the bench fixes one bit time in system clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module sstio_term #(parameter int BIT_CLKS = 128)
(
  // Clock
  input wire logic clock_i,
  // Serial lines and decoded character
  input wire logic line_i,
  output logic line_o,
  output logic [7:0] got_o
);
  initial line_o = 1'b1;
  initial got_o = 8'h00;
  task automatic send(input logic [7:0] ch);
    int i;
    @(negedge clock_i);
    line_o = 1'b0;
    repeat (BIT_CLKS) @(negedge clock_i);
    for (i = 0; i < 8; i++)
    begin
      line_o = ch[i];
      repeat (BIT_CLKS) @(negedge clock_i);
    end
    line_o = 1'b1;
    repeat (BIT_CLKS) @(negedge clock_i);
  endtask
  // Samples at mid-bit, so a ratio slip of more than half a bit corrupts the character.
  always
  begin : rx
    int i;
    @(negedge line_i);
    repeat (BIT_CLKS / 2) @(negedge clock_i);
    for (i = 0; i < 8; i++)
    begin
      repeat (BIT_CLKS) @(negedge clock_i);
      got_o[i] = line_i;
    end
    repeat (BIT_CLKS) @(negedge clock_i);
  end
endmodule
`default_nettype wire

// *** tb.sv ***
/*
 Self-checking bench for the serial terminal interface in its modem build at the high rate.
 Assumes a tick of eight clocks, so one bit is 16 ticks or 128 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sstio_map.vh"
module tb;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic fitted_i = 1'b1;
  logic enable_i = 1'b1;
  logic [7:0] term_got;
  logic io_strobe_i = 1'b0;
  logic [5:0] io_code_i = 6'h00;
  logic [2:0] io_pulse_i = 3'h0;
  logic [11:0] ac_i = 12'h000;
  logic [2:0] tick_cnt = 3'h0;
  logic [11:0] ac_o, r_ac;
  logic ac_valid_o, skip_o, tx_serial_o, rx_line, r_val, r_skip;
  logic receive_ready_flag_o, transmit_done_flag_o;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  always #10 clock_i = ~clock_i;
  always @(negedge clock_i) tick_cnt <= tick_cnt + 3'h1;
  sstio_top DUT (.clock_i(clock_i), .reset_n_i(reset_n_i), .enable_i(enable_i), .fitted_i(fitted_i),
    .modem_sel_i(1'b1), .high_rate_strap_i(1'b1), .xtal_tick_i(tick_cnt[2]), .io_strobe_i(io_strobe_i),
    .io_code_i(io_code_i), .io_pulse_i(io_pulse_i), .ac_i(ac_i), .ac_o(ac_o), .ac_valid_o(ac_valid_o),
    .skip_o(skip_o), .receive_serial_input_i(rx_line), .tx_serial_o(tx_serial_o),
    .receive_ready_flag_o(receive_ready_flag_o), .transmit_done_flag_o(transmit_done_flag_o));
  sstio_term #(.BIT_CLKS(128)) term (.clock_i(clock_i), .line_i(tx_serial_o), .line_o(rx_line), .got_o(term_got));
  task automatic end_sim;
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The answer is registered at the taking edge and stands only for the cycle after it.
  task automatic io(input logic [5:0] code, input logic [2:0] pulse, input logic [11:0] ac);
    @(negedge clock_i);
    io_strobe_i = 1'b1;
    io_code_i = code;
    io_pulse_i = pulse;
    ac_i = ac;
    @(negedge clock_i);
    io_strobe_i = 1'b0;
    r_ac = ac_o;
    r_val = ac_valid_o;
    r_skip = skip_o;
  endtask
  task automatic wait_hi(input bit tx);
    int n;
    for (n = 0; n < 3000 && (tx ? transmit_done_flag_o : receive_ready_flag_o) !== 1'b1; n++)
      @(negedge clock_i);
  endtask
  task automatic t_duplex;
    fork
      io(`SSTIO_TX_CODE, 3'h6, 12'ha50);
      term.send(8'h3c);
    join
    wait_hi(1'b1);
    wait_hi(1'b0);
    chk(term_got, 12'h0a5);
    io(`SSTIO_TX_CODE, 3'h1, 12'h000);
    chk(r_skip, 12'h001);
    io(`SSTIO_RX_CODE, 3'h1, 12'h000);
    chk(r_skip, 12'h001);
    io(`SSTIO_RX_CODE, 3'h6, 12'hfff);
    chk(r_ac, 12'h3c0);
    chk(r_val, 12'h001);
    chk(receive_ready_flag_o, 12'h000);
    io(`SSTIO_RX_CODE, 3'h4, 12'h00f);
    chk(r_ac, 12'h3cf);
    io(`SSTIO_RX_CODE, 3'h1, 12'h000);
    chk(r_skip, 12'h000);
  endtask
  task automatic t_tx_clear;
    io(`SSTIO_TX_CODE, 3'h2, 12'h000);
    chk(transmit_done_flag_o, 12'h000);
    io(`SSTIO_TX_CODE, 3'h6, 12'h010);
    wait_hi(1'b1);
    chk(term_got, 12'h001);
    chk(tx_serial_o, 12'h001);
  endtask
  // With the enable low the transmitter must hold its start bit however long the pause.
  task automatic t_freeze;
    io(`SSTIO_TX_CODE, 3'h6, 12'hff0);
    repeat (60) @(negedge clock_i);
    enable_i = 1'b0;
    repeat (400) @(negedge clock_i);
    chk(tx_serial_o, 12'h000);
    chk(transmit_done_flag_o, 12'h000);
    enable_i = 1'b1;
    wait_hi(1'b1);
    chk(transmit_done_flag_o, 12'h001);
  endtask
  task automatic t_unfitted;
    io(6'h22, 3'h6, 12'hfff);
    chk(r_val, 12'h000);
    fitted_i = 1'b0;
    term.send(8'h55);
    chk(receive_ready_flag_o, 12'h000);
    io(`SSTIO_RX_CODE, 3'h6, 12'hfff);
    chk(r_val, 12'h000);
    fitted_i = 1'b1;
  endtask
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  initial
  begin
    repeat (3) @(negedge clock_i);
    reset_n_i = 1'b1;
    chk({tx_serial_o, receive_ready_flag_o, transmit_done_flag_o}, 12'h004);
    repeat (8) @(negedge clock_i);
    t_duplex();
    t_tx_clear();
    t_freeze();
    t_unfitted();
    end_sim();
  end
endmodule
`default_nettype wire
